// File: rtl/asc_ctrl.sv
// Sample and conversion sequencer for the converter.
// Assumes control writes arrive as one-cycle strobes on mclk and that
// trigger events come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Stop-after-first-interrupt halts sequence at interrupt
// - Stop-after-first-interrupt clears auto-sample-start in hardware
// - Without stop bit, sequences keep overwriting results
// - Auto-sample restarts sampling after each conversion
// - Auto-sample sets sample-active on each start
// - Manual mode samples only when software sets bit
// - Sample-active reads one while sampling
// - Manual trigger: writing zero starts conversion
// - Nonzero trigger: hardware ends sampling itself
// - Done flag set when conversion finishes
// - Done clear leaves operations untouched
// - Done cleared when new conversion starts
module asc_ctrl
  import asc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic module_on,
  input wire logic [SRC_W-1:0] conversion_trigger_source,
  input wire logic [SEQ_W-1:0] convs_per_irq,
  input wire logic trigger_event,
  input wire logic wr_stop_after_first_irq,
  input wire logic wdata_stop_after_first_irq,
  input wire logic wr_auto_sample_start,
  input wire logic wdata_auto_sample_start,
  input wire logic wr_sample_active,
  input wire logic wdata_sample_active,
  input wire logic wr_done,
  input wire logic wdata_done,
  output logic stop_after_first_irq,
  output logic auto_sample_start,
  output logic sample_active,
  output logic done,
  output logic [CTRL_W-1:0] converter_control_one,
  output logic conv_start,
  output logic converter_irq
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  asc_state_e state;
  asc_state_e next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [SEQ_W-1:0] seq_cnt;
  logic halted;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire manual_src = (conversion_trigger_source == SRC_MANUAL);
  wire in_idle = (state == ASC_IDLE);
  wire in_smpl = (state == ASC_SAMPLE);
  wire in_conv = (state == ASC_CONVERT);
  wire cnt_zero = (cnt == '0);
  wire conv_end = module_on && in_conv && cnt_zero;
  wire seq_last = (seq_cnt + SEQ_ONE >= convs_per_irq);
  wire irq_now = conv_end && seq_last;
  wire stop_now = irq_now && stop_after_first_irq;
  wire sw_start = wr_sample_active && wdata_sample_active &&
                  !auto_sample_start && in_idle;
  wire auto_start = auto_sample_start && !stop_now &&
                    (in_idle || conv_end);
  wire man_end = manual_src && wr_sample_active &&
                 !wdata_sample_active;
  wire trig_end = !manual_src && trigger_event &&
                  cnt_zero;
  wire smpl_end = module_on && in_smpl && (man_end || trig_end);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
    end
    unique case (state)
      ASC_IDLE: begin
        if (module_on && (sw_start || auto_start)) begin
          next_state = ASC_SAMPLE;
          next_cnt = CNT_W'(SMPL_CYC);
        end
      end
      ASC_SAMPLE: begin
        if (!module_on) begin
          next_state = ASC_IDLE;
        end else if (smpl_end) begin
          next_state = ASC_CONVERT;
          next_cnt = CNT_W'(CONV_CYC - 1);
        end
      end
      ASC_CONVERT: begin
        if (!module_on) begin
          next_state = ASC_IDLE;
        end else if (conv_end) begin
          next_state = auto_start ? ASC_SAMPLE : ASC_IDLE;
          next_cnt = CNT_W'(SMPL_CYC);
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ASC_IDLE;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // ------------------------------------------------------------
  // Sequence counter and halt marker
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seq_cnt <= '0;
      halted <= 1'b0;
    end else begin
      if (irq_now || !module_on) begin
        seq_cnt <= '0;
      end else if (conv_end) begin
        seq_cnt <= seq_cnt + SEQ_ONE;
      end
      if (stop_now) begin
        halted <= 1'b1;
      end else if (next_state == ASC_SAMPLE) begin
        halted <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Control bits
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stop_after_first_irq <= 1'b0;
      auto_sample_start <= 1'b0;
    end else begin
      if (wr_stop_after_first_irq) begin
        stop_after_first_irq <= wdata_stop_after_first_irq;
      end
      // Hardware clear wins over a write
      if (stop_now) begin
        auto_sample_start <= 1'b0;
      end else if (wr_auto_sample_start) begin
        auto_sample_start <= wdata_auto_sample_start;
      end
    end
  end

  assign sample_active = in_smpl;

  // ------------------------------------------------------------
  // Done flag and event outputs
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      conv_start <= 1'b0;
      converter_irq <= 1'b0;
    end else begin
      conv_start <= smpl_end;
      converter_irq <= irq_now;
      // Set on finish, set wins over clear
      if (conv_end) begin
        done <= 1'b1;
      end else if (smpl_end) begin
        done <= 1'b0;
      end else if (wr_done && !wdata_done) begin
        done <= 1'b0;
      end
    end
  end

  assign converter_control_one = {
    3'h0, stop_after_first_irq, 1'b0, auto_sample_start,
    sample_active, done};

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_done_on_end:
    assert property (@(posedge mclk) disable iff (!rst_n)
      conv_end |=> done)
    else $error("done not set after conversion end");
  a_done_clr_start:
    assert property (@(posedge mclk) disable iff (!rst_n)
      smpl_end |=> !done && conv_start)
    else $error("done not cleared at conversion start");
  a_auto_hw_clear:
    assert property (@(posedge mclk) disable iff (!rst_n)
      stop_now |=> !auto_sample_start && converter_irq)
    else $error("auto sample start not cleared");
  a_stop_halts:
    assert property (@(posedge mclk) disable iff (!rst_n)
      stop_now |=> in_idle [*2])
    else $error("sequence did not halt");
  a_auto_restart:
    assert property (@(posedge mclk) disable iff (!rst_n)
      conv_end && auto_sample_start && !stop_now |=> sample_active)
    else $error("no automatic resample");
  a_manual_end:
    assert property (@(posedge mclk) disable iff (!rst_n)
      module_on && in_smpl && manual_src && wr_sample_active &&
      !wdata_sample_active |=> in_conv)
    else $error("manual end ignored");
  a_trig_hold:
    assert property (@(posedge mclk) disable iff (!rst_n)
      in_smpl && !manual_src && !trigger_event && module_on
      |=> sample_active)
    else $error("sampling ended without trigger");
  a_sw_start:
    assert property (@(posedge mclk) disable iff (!rst_n)
      in_idle && !auto_sample_start && !(wr_sample_active &&
      wdata_sample_active) |=> !sample_active)
    else $error("sampling began without software");
  a_conv_len:
    assert property (@(posedge mclk) disable iff (!rst_n)
      smpl_end |-> ##[1:20] conv_end || !module_on)
    else $error("conversion too long");
  c_auto_seq:
    cover property (@(posedge mclk) conv_end && auto_start);
  c_stop_irq:
    cover property (@(posedge mclk) stop_now);
  c_manual_conv:
    cover property (@(posedge mclk) smpl_end && manual_src);
  c_done_clear:
    cover property (@(posedge mclk) done && wr_done && !wdata_done);
  c_grouped_irq:
    cover property (@(posedge mclk) irq_now && seq_cnt != '0);

  // ------------------------------------------------------------
  // Sequence and interrupt checks
  // ------------------------------------------------------------
  a_halt_idle:
    assert property (@(posedge mclk) disable iff (!rst_n)
      halted |-> in_idle)
    else $error("sequence running after stop");
  a_conv_keeps:
    assert property (@(posedge mclk) disable iff (!rst_n)
      in_conv && !cnt_zero && module_on && wr_done && !wdata_done
      |=> in_conv)
    else $error("done clear disturbed conversion");
  a_done_holds:
    assert property (@(posedge mclk) disable iff (!rst_n)
      done && !smpl_end && !(wr_done && !wdata_done) |=> done)
    else $error("done dropped without clear");
  a_irq_source:
    assert property (@(posedge mclk) disable iff (!rst_n)
      converter_irq |-> $past(conv_end))
    else $error("interrupt without conversion end");
  a_irq_every:
    assert property (@(posedge mclk) disable iff (!rst_n)
      conv_end && convs_per_irq <= SEQ_ONE |=> converter_irq)
    else $error("interrupt missing after conversion");
  a_irq_group:
    assert property (@(posedge mclk) disable iff (!rst_n)
      conv_end && !seq_last |=> !converter_irq)
    else $error("interrupt raised inside sequence");
  a_off_idle:
    assert property (@(posedge mclk) disable iff (!rst_n)
      !module_on |=> !sample_active)
    else $error("sampling while module off");
  a_auto_sets:
    assert property (@(posedge mclk) disable iff (!rst_n)
      in_idle && auto_sample_start && module_on |=> sample_active)
    else $error("auto start did not set sampling");
  a_keep_going:
    assert property (@(posedge mclk) disable iff (!rst_n)
      irq_now && !stop_after_first_irq && auto_sample_start
      |=> sample_active)
    else $error("sequence stopped without stop bit");
  a_start_one:
    assert property (@(posedge mclk) disable iff (!rst_n)
      sw_start && module_on |=> sample_active)
    else $error("software start ignored");
  a_cs_pulse:
    assert property (@(posedge mclk) disable iff (!rst_n)
      conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");

endmodule // asc_ctrl

`default_nettype wire

// File: rtl/asc_pkg.sv
// Constants for the converter sample/convert sequencer.
// Assumes a single 25 MHz clock domain.
package asc_pkg;
  // ------------------------------------------------------------
  // Field layout of control register one
  // ------------------------------------------------------------
  localparam int unsigned DONE_BIT = 0;
  localparam int unsigned SMPL_BIT = 1;
  localparam int unsigned AUTO_BIT = 2;
  localparam int unsigned CLRA_BIT = 4;
  localparam int unsigned CTRL_W = 8;
  // ------------------------------------------------------------
  // Trigger source codes and timing
  // ------------------------------------------------------------
  localparam int unsigned SRC_W = 3;
  localparam logic [SRC_W-1:0] SRC_MANUAL = 3'h0;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned CONV_NS = 480;
  localparam int unsigned CONV_CYC = (CONV_NS * CLK_MHZ) / 1000;
  localparam int unsigned SMPL_NS = 80;
  localparam int unsigned SMPL_CYC = (SMPL_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned SEQ_W = 4;
  localparam logic [SEQ_W-1:0] SEQ_ONE = 4'h1;
  typedef enum logic [1:0] {
    ASC_IDLE,
    ASC_SAMPLE,
    ASC_CONVERT
  } asc_state_e;
endpackage

// File: test/asc_ctrl_tb.sv
// Self-checking bench for the converter sample/convert sequencer.
// Assumes asc_pkg is compiled first; single mclk domain, no partner model.
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl_tb;
  import asc_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic on = 1'b0;
  logic trig = 1'b0;
  logic [SRC_W-1:0] src = SRC_MANUAL;
  logic [3:0] wr = 4'h0;
  logic [3:0] wd = 4'h0;
  logic [SEQ_W-1:0] cpi = SEQ_ONE;
  logic stop_q, auto_q, smp_q, done_q, cs, irq;
  logic [CTRL_W-1:0] ctrl;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  asc_ctrl dut (.mclk(mclk), .rst_n(rst_n), .module_on(on),
    .conversion_trigger_source(src), .convs_per_irq(cpi),
    .trigger_event(trig), .wr_stop_after_first_irq(wr[3]),
    .wdata_stop_after_first_irq(wd[3]), .wr_auto_sample_start(wr[2]),
    .wdata_auto_sample_start(wd[2]), .wr_sample_active(wr[1]),
    .wdata_sample_active(wd[1]), .wr_done(wr[0]), .wdata_done(wd[0]),
    .stop_after_first_irq(stop_q), .auto_sample_start(auto_q),
    .sample_active(smp_q), .done(done_q), .converter_control_one(ctrl),
    .conv_start(cs), .converter_irq(irq));
  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      finish_test();
    end
  end
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: pick = smp_q;
      1: pick = cs;
      2: pick = done_q;
      default: pick = irq;
    endcase
  endfunction
  task automatic wait_sig(input int k, input logic v, input int lim,
                          input string nm);
    for (int i = 0; i < lim && pick(k) !== v; i++) @(negedge mclk);
    check(nm, {7'h0, pick(k)}, {7'h0, v});
  endtask
  // One-cycle write strobe; bit index 3 stop, 2 auto, 1 sample, 0 done
  task automatic wbit(input int b, input logic v);
    @(negedge mclk);
    wr[b] = 1'b1;
    wd[b] = v;
    @(negedge mclk);
    wr = 4'h0;
  endtask
  task automatic pulse_trig();
    repeat (3) @(negedge mclk);
    trig = 1'b1;
    @(negedge mclk);
    trig = 1'b0;
  endtask
  // Follows one conversion from its start pulse to completion
  task automatic conv_check(input logic clr);
    wait_sig(1, 1'b1, 4, "conv_start");
    check("done_at_start", {7'h0, done_q}, 8'h0);
    if (clr) begin
      wbit(0, 1'b0);
      repeat (CONV_CYC - 4) @(negedge mclk);
    end else begin
      repeat (CONV_CYC - 2) @(negedge mclk);
    end
    check("done_early", {7'h0, done_q}, 8'h0);
    wait_sig(2, 1'b1, 4, "done");
    check("irq", {7'h0, irq}, 8'h1);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_manual();
    wbit(1, 1'b1);
    wait_sig(0, 1'b1, 3, "sample_start");
    check("ctrl_sample", {7'h0, ctrl[SMPL_BIT]}, 8'h1);
    repeat (4) @(negedge mclk);
    check("sample_hold", {7'h0, smp_q}, 8'h1);
    wbit(1, 1'b0);
    conv_check(1'b1);
    check("ctrl_done", {7'h0, ctrl[DONE_BIT]}, 8'h1);
    check("sample_idle", {7'h0, smp_q}, 8'h0);
  endtask
  // Module switched off while sampling
  task automatic t_off();
    wbit(1, 1'b1);
    @(negedge mclk);
    on = 1'b0;
    // no access in the cycle after disable
    repeat (2) @(negedge mclk);
    check("off_idle", {7'h0, smp_q}, 8'h0);
    on = 1'b1;
  endtask
  task automatic t_trigger();
    src = 3'h1;
    wbit(1, 1'b1);
    wait_sig(0, 1'b1, 3, "sample_start");
    pulse_trig();
    wait_sig(0, 1'b0, 3, "sample_hw_end");
    conv_check(1'b0);
  endtask
  // Two conversions per interrupt
  task automatic t_group();
    cpi = 4'h2;
    for (int n = 1; n <= 2; n++) begin
      wbit(1, 1'b1);
      pulse_trig();
      wait_sig(1, 1'b1, 4, "group_start");
      wait_sig(2, 1'b1, CONV_CYC + 2, "group_done");
      check("group_irq", {7'h0, irq}, 8'(n / 2));
    end
    cpi = SEQ_ONE;
  endtask
  task automatic t_auto();
    wbit(2, 1'b1);
    wait_sig(0, 1'b1, 4, "auto_sample");
    repeat (2) begin
      pulse_trig();
      conv_check(1'b0);
      wait_sig(0, 1'b1, 3, "auto_restart");
    end
    wbit(3, 1'b1);
    check("ctrl_stop", {7'h0, ctrl[CLRA_BIT]}, 8'h1);
    pulse_trig();
    conv_check(1'b0);
    repeat (2) @(negedge mclk);
    check("auto_hw_clr", {6'h0, auto_q, ctrl[AUTO_BIT]}, 8'h0);
    repeat (6) @(negedge mclk);
    check("halted", {7'h0, smp_q | cs}, 8'h0);
  endtask
  task automatic finish_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    check("reset_ctrl", ctrl, 8'h00);
    rst_n = 1'b1;
    on = 1'b1;
    @(negedge mclk);
    t_manual();
    t_off();
    t_manual();
    t_trigger();
    t_group();
    t_auto();
    finish_test();
  end
endmodule // asc_ctrl_tb
`default_nettype wire
